// >>> src/lsc_pkg.sv
package lsc_pkg;

    // ----------------
    // Register indices (byte address / 4)
    // ----------------
    localparam logic [7:0] LSC_IDX_STATUS   = 8'h48;
    localparam logic [7:0] LSC_IDX_MANTISSA = 8'h4a;
    localparam logic [7:0] LSC_IDX_CTRL2    = 8'h4c;
    localparam logic [7:0] LSC_IDX_CTRL3    = 8'h4d;
    localparam logic [7:0] LSC_IDX_HLEN     = 8'h4e;
    localparam logic [7:0] LSC_IDX_FRACTION = 8'h4f;
    localparam int         LSC_ADDR_W       = 12;

    // ----------------
    // Field positions
    // ----------------
    localparam int LSC_CR2_MUTE   = 1;
    localparam int LSC_CR2_BREAK  = 0;
    localparam int LSC_CR3_DUM    = 7;
    localparam int LSC_CR3_LINE   = 6;
    localparam int LSC_CR3_SLV    = 5;
    localparam int LSC_CR3_ASE    = 4;
    localparam int LSC_CR3_HDM    = 3;
    localparam int LSC_CR3_HIE    = 2;
    localparam int LSC_CR3_HDF    = 1;
    localparam int LSC_CR3_SFS    = 0;

    // ----------------
    // Reset values and codes
    // ----------------
    localparam logic [7:0] LSC_RST_BYTE   = 8'h00;
    localparam logic [3:0] LSC_RST_FRAC   = 4'h0;
    localparam logic [7:0] LSC_HLEN_BREAK = 8'hff;
    localparam logic [7:0] LSC_HLEN_TMO   = 8'h00;
    localparam logic [7:0] LSC_MANT_OFF   = 8'h00;

    // ----------------
    // Bit-time counts
    // ----------------
    localparam logic [3:0] LSC_BRK_MASTER  = 4'hd;  // 13 low bits
    localparam logic [3:0] LSC_BRK_NORMAL  = 4'ha;  // 10 low bits
    localparam logic [3:0] LSC_BRK_DETECT  = 4'hb;  // 11 dominant bits
    localparam int         LSC_HDR_MAX     = 57;
    localparam logic [7:0] LSC_HDR_MAX_QTR = 8'(LSC_HDR_MAX * 4);

    typedef enum logic [1:0] {
        LSC_BRK_IDLE = 2'b00,
        LSC_BRK_WAIT = 2'b01,
        LSC_BRK_SEND = 2'b11
    } lsc_brk_e;

endpackage

// >>> src/lsc_break_det.sv
`timescale 1ns/1ps

module lsc_break_det (
    input  wire logic pclk,         // system clock
    input  wire logic presetn,      // async reset, active low
    input  wire logic enable,       // detection armed
    input  wire logic rx_level,     // synchronised receive line
    input  wire logic bit_tick,     // one pulse per bit time
    output logic      break_pulse   // one-cycle pulse on break
);
    import lsc_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic       fired;
        logic       pulse;
    } lsc_det_s;

    lsc_det_s s_ff;
    lsc_det_s nxt_s;

    // ----------------
    // Count consecutive dominant bit times
    // ----------------
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.pulse = 1'b0;
        if (!enable || rx_level) begin
            nxt_s.cnt   = 4'h0;
            nxt_s.fired = 1'b0;
        end else if (bit_tick && !s_ff.fired) begin
            if (s_ff.cnt == LSC_BRK_DETECT - 4'h1) begin
                nxt_s.pulse = 1'b1;          // see R8
                nxt_s.fired = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign break_pulse = s_ff.pulse;

endmodule

// >>> src/lsc_lin_ctrl.sv
// Functional notes
// R1: Mute bit; hardware clears it on wake-up.
// R2: Slave with receive full: mute writes ignored.
// R3: Send-break sends breaks; set then clear sends one.
// R4: Update method 0 loads now, 1 at next character.
// R5: Deferred load without write reloads old divider.
// R6: Enable 0 off; 1/0 master; 1/1 slave.
// R7: Master break is 13 low bit times.
// R8: Slave detects break at 11 dominant bits.
// R9: Slave mode ignores send-break writes.
// R10: Slave maps mantissa and fraction.
// R11: Auto-synch enable turns synch unit on.
// R12: Header method 0 break, 1 identifier; picks wake.
// R13: Header irq enable gates header flag irq.
// R14: Header flag cleared by status access, then ctrl3 read.
// R15: Method 0 flags at break, 1 after identifier.
// R16: Synch state set at break, cleared at synch end.
// R17: Software clear of synch state returns to idle.
// R18: Synch state with auto-synch counts falling edges.
// R19: Mantissa 00h stops serial clocks in slave mode.
// R20: Fraction in sixteenths; upper bits read zero.
// R21: Mantissa write commits divider with fraction.
// R22: Software avoids read-modify-write on divider.
// R23: Header length hidden unless auto-synch or id detect.
// R24: Header length FFh at break, 00h timeout, code at header.
// R25: Length code is 57 minus duration, quarter bits.
// R26: Header length writes are ignored.
`timescale 1ns/1ps

module lsc_lin_ctrl (
    input  wire logic                            pclk,        // clock
    input  wire logic                            presetn,     // reset, low
    input  wire logic                            psel,        // APB select
    input  wire logic                            penable,     // APB enable
    input  wire logic                            pwrite,      // APB write
    input  wire logic [lsc_pkg::LSC_ADDR_W-1:0]  paddr,       // byte addr
    input  wire logic [31:0]                     pwdata,      // write data
    output logic [31:0]                          prdata,      // read data
    output logic                                 pready,      // APB ready
    output logic                                 pslverr,     // unmapped
    input  wire logic                            rxd_pin,     // rx pin
    input  wire logic                            bit_tick,    // bit pulse
    input  wire logic                            rx_full,     // data full
    input  wire logic                            rx_char,     // char pulse
    input  wire logic                            wake_detect, // normal wake
    input  wire logic                            synch_done,  // synch end
    input  wire logic                            ident_done,  // id received
    input  wire logic                            hdr_timeout, // hdr timeout
    input  wire logic [7:0]                      hdr_quarters,// hdr length
    input  wire logic                            asu_load,    // synch load
    input  wire logic [11:0]                     asu_value,   // synch value
    input  wire logic                            tx_word_end, // tx free
    input  wire logic [7:0]                      status_in,   // status bits
    output logic                                 tx_break,    // drive low
    output logic                                 receiver_mute,// mute mode
    output logic                                 header_wake_sel,// method
    output logic                                 asu_enable,  // synch unit
    output logic [11:0]                          baud_divider,// divider
    output logic                                 sci_clk_run, // clocks on
    output logic [3:0]                           synch_edges, // fall count
    output logic                                 header_irq   // interrupt
);
    import lsc_pkg::*;

    typedef struct packed {
        logic       rx_meta;
        logic       rx_sync;
        logic       rx_prev;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] mant;
        logic [3:0] frac;
        logic [11:0] divider;
        logic [7:0] hlen;
        logic       sr_armed;
        logic       got_synch;
        logic       brk_pend;
        lsc_brk_e   brk_st;
        logic [3:0] brk_bits;
        logic [3:0] edges;
        logic [7:0] rdata;
    } lsc_state_s;

    lsc_state_s s_ff;
    lsc_state_s nxt_s;
    logic       brk_det;
    logic       slave;
    logic       master;
    logic       access;
    logic       mapped;
    logic [7:0] idx;
    logic [3:0] brk_len;

    // ----------------
    // Address decode
    // ----------------
    function automatic logic [7:0] addr_index(
        input logic [LSC_ADDR_W-1:0] a
    );
        return a[9:2];
    endfunction

    function automatic logic is_mapped(
        input logic [LSC_ADDR_W-1:0] a,
        input logic                  slv
    );
        logic [7:0] i;
        i = addr_index(a);
        if (a[1:0] != 2'b00 || a[LSC_ADDR_W-1:10] != '0) begin
            return 1'b0;
        end
        if (i == LSC_IDX_STATUS || i == LSC_IDX_CTRL2
            || i == LSC_IDX_CTRL3) begin
            return 1'b1;
        end
        return slv && (i == LSC_IDX_MANTISSA || i == LSC_IDX_FRACTION
                       || i == LSC_IDX_HLEN);                  // see R10
    endfunction

    assign slave   = s_ff.ctrl3[LSC_CR3_LINE] && s_ff.ctrl3[LSC_CR3_SLV];
    assign master  = s_ff.ctrl3[LSC_CR3_LINE] && !s_ff.ctrl3[LSC_CR3_SLV];
    assign idx     = addr_index(paddr);
    assign mapped  = is_mapped(paddr, slave);
    assign access  = psel && penable;
    assign brk_len = master ? LSC_BRK_MASTER : LSC_BRK_NORMAL;  // see R7

    // ----------------
    // Break detector
    // ----------------
    lsc_break_det u_break_det (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (slave),
        .rx_level    (s_ff.rx_sync),
        .bit_tick    (bit_tick),
        .break_pulse (brk_det)
    );

    // ----------------
    // Next-state logic
    // ----------------
    always_comb begin
        logic [7:0] code;
        code    = 8'h00;
        nxt_s   = s_ff;
        nxt_s.rx_meta = rxd_pin;
        nxt_s.rx_sync = s_ff.rx_meta;
        nxt_s.rx_prev = s_ff.rx_sync;

        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            nxt_s.rdata = 8'h00;
            if (mapped) begin
                unique case (idx)
                    LSC_IDX_STATUS:   nxt_s.rdata = status_in;
                    LSC_IDX_CTRL2:    nxt_s.rdata = s_ff.ctrl2;
                    LSC_IDX_CTRL3:    nxt_s.rdata = s_ff.ctrl3;
                    LSC_IDX_MANTISSA: nxt_s.rdata = s_ff.mant;
                    LSC_IDX_FRACTION:
                        nxt_s.rdata = {4'h0, s_ff.frac};        // see R20
                    LSC_IDX_HLEN: begin
                        if (s_ff.ctrl3[LSC_CR3_ASE]
                            || s_ff.ctrl3[LSC_CR3_HDM]) begin
                            nxt_s.rdata = s_ff.hlen;            // see R23
                        end
                    end
                    default: nxt_s.rdata = 8'h00;
                endcase
            end
        end

        // Register writes
        if (access && pwrite && mapped) begin
            unique case (idx)
                LSC_IDX_CTRL2: begin
                    nxt_s.ctrl2[7:2] = pwdata[7:2];
                    if (!(slave && rx_full)) begin              // see R2
                        nxt_s.ctrl2[LSC_CR2_MUTE] = pwdata[LSC_CR2_MUTE];
                    end
                    if (!slave) begin                           // see R9
                        nxt_s.ctrl2[LSC_CR2_BREAK] = pwdata[LSC_CR2_BREAK];
                        if (pwdata[LSC_CR2_BREAK]
                            && !s_ff.ctrl2[LSC_CR2_BREAK]) begin
                            nxt_s.brk_pend = 1'b1;              // see R3
                        end
                    end
                end
                LSC_IDX_CTRL3: begin
                    nxt_s.ctrl3[7:2] = pwdata[7:2];             // see R6
                    if (!pwdata[LSC_CR3_SFS]) begin
                        nxt_s.ctrl3[LSC_CR3_SFS] = 1'b0;        // see R17
                        nxt_s.got_synch          = 1'b0;
                    end
                end
                LSC_IDX_MANTISSA: begin
                    nxt_s.mant = pwdata[7:0];
                    if (!s_ff.ctrl3[LSC_CR3_DUM] && !asu_load) begin
                        nxt_s.divider = {pwdata[7:0], s_ff.frac}; // see R21
                    end                                         // see R4
                end
                LSC_IDX_FRACTION: nxt_s.frac = pwdata[3:0];     // see R20
                default: ;                                      // see R26
            endcase
        end

        // Flag clear: status access, then ctrl3 read
        if (access && mapped && idx == LSC_IDX_STATUS) begin
            nxt_s.sr_armed = 1'b1;
        end
        if (access && !pwrite && mapped && idx == LSC_IDX_CTRL3
            && s_ff.sr_armed) begin
            nxt_s.ctrl3[LSC_CR3_HDF] = 1'b0;                    // see R14
            nxt_s.sr_armed           = 1'b0;
        end

        // Divider updates from the receive side
        if (slave && s_ff.ctrl3[LSC_CR3_ASE] && asu_load) begin
            nxt_s.divider = asu_value;                          // see R11
        end
        if (slave && rx_char && s_ff.ctrl3[LSC_CR3_DUM]) begin
            nxt_s.divider = {nxt_s.mant, nxt_s.frac};           // see R5
        end
        if (slave && rx_char) begin
            nxt_s.ctrl3[LSC_CR3_DUM] = 1'b0;                    // see R4
        end

        // Wake-up outside slave mode
        if (!slave && wake_detect) begin
            nxt_s.ctrl2[LSC_CR2_MUTE] = 1'b0;                   // see R1
        end

        // Header tracking in slave mode
        if (slave) begin
            if (s_ff.ctrl3[LSC_CR3_SFS] && s_ff.ctrl3[LSC_CR3_ASE]
                && s_ff.rx_prev && !s_ff.rx_sync) begin
                nxt_s.edges = s_ff.edges + 4'h1;                // see R18
            end
            if (synch_done && s_ff.ctrl3[LSC_CR3_SFS]) begin
                nxt_s.ctrl3[LSC_CR3_SFS] = 1'b0;                // see R16
                nxt_s.got_synch          = 1'b1;
            end
            if (ident_done && s_ff.got_synch) begin
                code = (hdr_quarters > LSC_HDR_MAX_QTR) ? 8'h00
                       : LSC_HDR_MAX_QTR - hdr_quarters;        // see R25
                nxt_s.hlen      = code;                         // see R24
                nxt_s.got_synch = 1'b0;
                if (s_ff.ctrl3[LSC_CR3_HDM]) begin
                    nxt_s.ctrl3[LSC_CR3_HDF]  = 1'b1;           // see R15
                    nxt_s.ctrl2[LSC_CR2_MUTE] = 1'b0;           // see R12
                end
            end
            if (hdr_timeout) begin
                nxt_s.hlen               = LSC_HLEN_TMO;        // see R24
                nxt_s.ctrl3[LSC_CR3_SFS] = 1'b0;
                nxt_s.got_synch          = 1'b0;
            end
            if (brk_det) begin
                nxt_s.hlen               = LSC_HLEN_BREAK;      // see R24
                nxt_s.ctrl3[LSC_CR3_SFS] = 1'b1;                // see R16
                nxt_s.got_synch          = 1'b0;
                nxt_s.edges              = 4'h0;
                if (!s_ff.ctrl3[LSC_CR3_HDM]) begin
                    nxt_s.ctrl3[LSC_CR3_HDF]  = 1'b1;           // see R15
                    nxt_s.ctrl2[LSC_CR2_MUTE] = 1'b0;           // see R12
                end
            end
        end else begin
            nxt_s.got_synch = 1'b0;
        end

        // Break transmitter
        unique case (s_ff.brk_st)
            LSC_BRK_IDLE: begin
                if (!slave && (s_ff.brk_pend
                               || s_ff.ctrl2[LSC_CR2_BREAK])) begin
                    nxt_s.brk_st   = LSC_BRK_WAIT;
                    nxt_s.brk_pend = 1'b0;
                end
            end
            LSC_BRK_WAIT: begin
                if (tx_word_end) begin                          // see R3
                    nxt_s.brk_st   = LSC_BRK_SEND;
                    nxt_s.brk_bits = 4'h0;
                end
            end
            LSC_BRK_SEND: begin
                if (bit_tick) begin
                    if (s_ff.brk_bits == brk_len - 4'h1) begin  // see R7
                        nxt_s.brk_bits = 4'h0;
                        if (slave || !s_ff.ctrl2[LSC_CR2_BREAK]) begin
                            nxt_s.brk_st = LSC_BRK_IDLE;
                        end
                    end else begin
                        nxt_s.brk_bits = s_ff.brk_bits + 4'h1;
                    end
                end
            end
            default: nxt_s.brk_st = LSC_BRK_IDLE;
        endcase
        if (slave) begin
            nxt_s.brk_pend = 1'b0;                              // see R9
        end
    end

    // ----------------
    // State register
    // ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff         <= '0;
            s_ff.rx_meta <= 1'b1;
            s_ff.rx_sync <= 1'b1;
            s_ff.rx_prev <= 1'b1;
            s_ff.ctrl2   <= LSC_RST_BYTE;
            s_ff.ctrl3   <= LSC_RST_BYTE;
            s_ff.mant    <= LSC_RST_BYTE;
            s_ff.frac    <= LSC_RST_FRAC;
            s_ff.hlen    <= LSC_RST_BYTE;
            s_ff.brk_st  <= LSC_BRK_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------
    // Outputs
    // ----------------
    assign prdata          = {24'h000000, s_ff.rdata};
    assign pready          = penable;
    assign pslverr         = access && !mapped;
    assign tx_break        = (s_ff.brk_st == LSC_BRK_SEND);
    assign receiver_mute   = s_ff.ctrl2[LSC_CR2_MUTE];
    assign header_wake_sel = slave && s_ff.ctrl3[LSC_CR3_HDM];   // see R12
    assign asu_enable      = slave && s_ff.ctrl3[LSC_CR3_ASE];   // see R11
    assign baud_divider    = s_ff.divider;
    assign sci_clk_run     = !slave || (s_ff.mant != LSC_MANT_OFF); // see R19
    assign synch_edges     = s_ff.edges;
    assign header_irq      = slave && s_ff.ctrl3[LSC_CR3_HIE]
                             && s_ff.ctrl3[LSC_CR3_HDF];         // see R13

endmodule

// >>> test/lsc_lin_ctrl_properties.sv
`timescale 1ns/1ps

module lsc_lin_ctrl_properties (
    input wire logic        pclk,            // clock
    input wire logic        presetn,         // reset
    input wire logic        psel,            // select
    input wire logic        penable,         // enable
    input wire logic        pwrite,          // write
    input wire logic [11:0] paddr,           // address
    input wire logic [31:0] pwdata,          // wdata
    input wire logic [31:0] prdata,          // rdata
    input wire logic        pslverr,         // error
    input wire logic        bit_tick,        // bit pulse
    input wire logic        rx_full,         // rx full
    input wire logic        tx_break,        // break
    input wire logic        receiver_mute,   // mute
    input wire logic        header_wake_sel, // method
    input wire logic        asu_enable,      // synch
    input wire logic        sci_clk_run,     // clocks
    input wire logic        header_irq       // irq
);
    logic       acc;
    logic [7:0] wd_ff;
    logic [4:0] ticks_ff;
    assign acc = psel && penable;
    // Previous-cycle write-data byte; bit ticks while a break is out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_ff    <= 8'h00;
            ticks_ff <= 5'h00;
        end else begin
            wd_ff    <= pwdata[7:0];
            ticks_ff <= tx_break ? ticks_ff + 5'(bit_tick) : 5'h00;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_map;
        acc && paddr == 12'h128 && asu_enable |-> !pslverr;
    endproperty
    a_map: assert property (p_map) else $error("map");
    property p_wsel;
        acc && pwrite && paddr == 12'h134
            |=> header_wake_sel == (&wd_ff[6:5] && wd_ff[3]);
    endproperty
    a_wsel: assert property (p_wsel) else $error("wake");
    property p_ase;
        acc && pwrite && paddr == 12'h134 |=> asu_enable == &wd_ff[6:4];
    endproperty
    a_ase: assert property (p_ase) else $error("synch");
    property p_clk_off;
        acc && pwrite && paddr == 12'h128 && !pslverr
            && pwdata[7:0] == 8'h00 |=> !sci_clk_run;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock");
    property p_mute_hold;
        asu_enable && rx_full |=> !$rose(receiver_mute);
    endproperty
    a_mute_hold: assert property (p_mute_hold) else $error("mute");
    property p_frac_hi;
        acc && !pwrite && paddr == 12'h13c |-> prdata[31:4] == 28'h0;
    endproperty
    a_frac_hi: assert property (p_frac_hi) else $error("frac");
    property p_hlen_hide;
        acc && !pwrite && paddr == 12'h138 && !asu_enable
            && !header_wake_sel |-> prdata == 32'h0;
    endproperty
    a_hlen_hide: assert property (p_hlen_hide) else $error("hlen");
    property p_brk_len;
        $fell(tx_break) |-> ticks_ff == 5'd13 || ticks_ff == 5'd10;
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break");
    c_irq: cover property ($rose(header_irq));
    c_brk: cover property ($rose(tx_break));
    c_err: cover property (acc && pslverr);
endmodule

// >>> test/lsc_lin_node.sv
`timescale 1ns/1ps

module lsc_lin_node (
    input  wire logic       pclk,     // clock
    input  wire logic       presetn,  // reset, low
    input  wire logic       brk_go,   // start a break
    input  wire logic [3:0] brk_bits, // dominant bit times
    output logic            rxd,      // bus level seen by rx pin
    output logic            bit_tick  // bit-time pulse
);
    logic [1:0] div_ff;
    logic [3:0] left_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff   <= 2'd0;
            left_ff  <= 4'd0;
            rxd      <= 1'b1;
            bit_tick <= 1'b0;
        end else begin
            div_ff   <= div_ff + 2'd1;
            bit_tick <= (div_ff == 2'd3);
            if (brk_go) begin
                left_ff <= brk_bits;
                rxd     <= 1'b0;
            end else if (bit_tick && left_ff != 4'd0) begin
                left_ff <= left_ff - 4'd1;
            end else if (left_ff == 4'd0) begin
                rxd <= 1'b1;
            end
        end
    end
endmodule

// >>> test/lsc_lin_ctrl_bench.sv
`timescale 1ns/1ps

module lsc_lin_ctrl_bench;
    import lsc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rxd_pin, bit_tick, rx_full, rx_char, wake_detect, err;
    logic        synch_done, ident_done, hdr_timeout, asu_load, brk_go;
    logic        tx_word_end, tx_break, receiver_mute, header_wake_sel;
    logic        asu_enable, sci_clk_run, header_irq;
    logic [11:0] paddr, asu_value, baud_divider;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  hdr_quarters, status_in, m, m2, f, q;
    logic [3:0]  synch_edges;
    int          bad_count, samples_checked, n;

    lsc_lin_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rxd_pin, .bit_tick, .rx_full,
        .rx_char, .wake_detect, .synch_done, .ident_done, .hdr_timeout,
        .hdr_quarters, .asu_load, .asu_value, .tx_word_end, .status_in,
        .tx_break, .receiver_mute, .header_wake_sel, .asu_enable,
        .baud_divider, .sci_clk_run, .synch_edges, .header_irq);
    lsc_lin_node u_node (.pclk, .presetn, .brk_go, .brk_bits(4'd12),
        .rxd(rxd_pin), .bit_tick);

    function automatic logic [7:0] hlen_exp(input logic [7:0] qq);
        return (qq > LSC_HDR_MAX_QTR) ? 8'h00 : LSC_HDR_MAX_QTR - qq;
    endfunction
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= {24'($urandom), d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] idx,
                          input logic [7:0] e, input logic ee);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, rd);
        chk(nm, {31'h0, ee}, {31'h0, err});
    endtask
    task automatic ev(input int k);
        @(posedge pclk);
        {hdr_timeout, tx_word_end, ident_done, synch_done,
         rx_char} <= 5'(1 << k);
        @(posedge pclk);
        {hdr_timeout, tx_word_end, ident_done, synch_done,
         rx_char} <= 5'h0;
        @(negedge pclk);
    endtask
    task automatic brk_ticks(output int t);
        t = 0;
        for (int k = 0; k < 200; k++) begin
            @(negedge pclk);
            if (tx_break === 1'b1) begin
                t += int'(bit_tick === 1'b1);
            end else if (t > 0) begin
                break;
            end
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, rx_full, rx_char, synch_done} = '0;
        {ident_done, hdr_timeout, asu_load, wake_detect, brk_go} = '0;
        {presetn, tx_word_end, paddr, pwdata, asu_value} = '0;
        void'($urandom(58773));
        {status_in, hdr_quarters} = 16'($urandom);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl2", LSC_IDX_CTRL2, 8'h00, 1'b0);
        rd_chk("ctrl3", LSC_IDX_CTRL3, 8'h00, 1'b0);
        rd_chk("data", 8'h49, 8'h00, 1'b1);
        rd_chk("mant_off", LSC_IDX_MANTISSA, 8'h00, 1'b1);
        rd_chk("hlen_off", LSC_IDX_HLEN, 8'h00, 1'b1);
        rd_chk("status", LSC_IDX_STATUS, status_in, 1'b0);
        apb(1'b1, LSC_IDX_CTRL3, 8'h40);
        apb(1'b1, LSC_IDX_CTRL2, 8'h01);
        apb(1'b1, LSC_IDX_CTRL2, 8'h00);
        ev(3);
        brk_ticks(n);
        chk("master_break", 13, n);
        apb(1'b1, LSC_IDX_CTRL3, 8'h74);
        apb(1'b1, LSC_IDX_CTRL2, 8'h01);
        ev(3);
        brk_ticks(n);
        chk("slave_break", 0, n);
        {m, m2, f} = {8'($urandom_range(255, 1)), 8'($urandom_range(255, 1)),
                      8'($urandom)};
        apb(1'b1, LSC_IDX_FRACTION, f);
        apb(1'b1, LSC_IDX_MANTISSA, m);
        chk("div_now", {m, f[3:0]}, baud_divider);
        rd_chk("frac", LSC_IDX_FRACTION, {4'h0, f[3:0]}, 1'b0);
        rd_chk("mant", LSC_IDX_MANTISSA, m, 1'b0);
        apb(1'b1, LSC_IDX_MANTISSA, 8'h00);
        chk("clk_off", 0, sci_clk_run);
        apb(1'b1, LSC_IDX_CTRL3, 8'hf4);
        apb(1'b1, LSC_IDX_MANTISSA, m2);
        chk("div_wait", {8'h00, f[3:0]}, baud_divider);
        ev(0);
        chk("div_char", {m2, f[3:0]}, baud_divider);
        chk("clk_on", 1, sci_clk_run);
        rd_chk("ctrl3_dum", LSC_IDX_CTRL3, 8'h74, 1'b0);
        apb(1'b1, LSC_IDX_CTRL3, 8'hf4);
        ev(0);
        chk("div_old", {m2, f[3:0]}, baud_divider);
        apb(1'b1, LSC_IDX_CTRL2, 8'h02);
        chk("mute_set", 1, receiver_mute);
        @(posedge pclk);
        rx_full <= 1'b1;
        apb(1'b1, LSC_IDX_CTRL2, 8'h00);
        chk("mute_full", 1, receiver_mute);
        @(posedge pclk);
        {rx_full, brk_go} <= 2'b01;
        @(posedge pclk);
        brk_go <= 1'b0;
        for (int k = 0; k < 200 && header_irq !== 1'b1; k++) begin
            @(negedge pclk);
        end
        chk("irq", 1, header_irq);
        chk("mute_wake", 0, receiver_mute);
        rd_chk("ctrl3_hdr", LSC_IDX_CTRL3, 8'h77, 1'b0);
        rd_chk("hlen_brk", LSC_IDX_HLEN, LSC_HLEN_BREAK, 1'b0);
        ev(1);
        rd_chk("ctrl3_syn", LSC_IDX_CTRL3, 8'h76, 1'b0);
        q = $urandom_range(1) ? 8'hf0 : 8'($urandom_range(228));
        @(posedge pclk);
        hdr_quarters <= q;
        ev(2);
        apb(1'b1, LSC_IDX_HLEN, 8'($urandom));
        rd_chk("hlen", LSC_IDX_HLEN, hlen_exp(q), 1'b0);
        rd_chk("status", LSC_IDX_STATUS, status_in, 1'b0);
        rd_chk("ctrl3_clr", LSC_IDX_CTRL3, 8'h76, 1'b0);
        chk("irq_clr", 0, header_irq);
        ev(4);
        rd_chk("hlen_tmo", LSC_IDX_HLEN, LSC_HLEN_TMO, 1'b0);
        end_of_test;
    end
endmodule

bind lsc_lin_ctrl lsc_lin_ctrl_properties u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .bit_tick,
    .rx_full, .tx_break, .receiver_mute, .header_wake_sel, .asu_enable,
    .sci_clk_run, .header_irq);
